// [hw/pcs_port_bank.sv]
/*
 * Port configuration bank: selector, per-port configuration, data latches,
 * wake pending flags and comparator control for three ports.
 * Assumes the core issues one-cycle strobes on the core clock and that pin
 * and comparator inputs are asynchronous to it.
 */
module pcs_port_bank #(
	parameter bit HAS_PORT_C = 1'b1
) (
	input wire logic REF_CLK,
	input wire logic SYS_RST,
	input wire logic SEL_WR,
	input wire logic [7:0] SEL_WDATA,
	output logic [7:0] SEL_RDATA,
	input wire logic PCTL_WR,
	input wire logic [1:0] PCTL_PORT,
	input wire logic [7:0] PCTL_WDATA,
	output logic PCTL_XVALID,
	output logic [7:0] PCTL_XDATA,
	input wire logic [7:0] MEM_ADDR,
	input wire logic MEM_WR,
	input wire logic MEM_RD,
	input wire logic [7:0] MEM_WDATA,
	output logic MEM_HIT,
	output logic [7:0] MEM_RDATA,
	input wire logic [7:0] PA_IN,
	output logic [7:0] PA_OUT,
	output logic [7:0] PA_OE_N,
	input wire logic [7:0] PB_IN,
	output logic [7:0] PB_OUT,
	output logic [7:0] PB_OE_N,
	input wire logic [7:0] PC_IN,
	output logic [7:0] PC_OUT,
	output logic [7:0] PC_OE_N,
	output pcs_pkg::pcs_pad_cfg_t PA_PAD,
	output pcs_pkg::pcs_pad_cfg_t PB_PAD,
	output pcs_pkg::pcs_pad_cfg_t PC_PAD,
	input wire logic CMP_GT,
	output logic CMP_ENABLE_N,
	output logic [7:0] WAKE_PENDING
);
	import pcs_pkg::*;

	logic [7:0] sel_q;
	pcs_port_cfg_t cfg_q [3];
	logic [7:0] data_q [3];
	logic [7:0] ram_q;
	logic [7:0] wake_en_n_q;
	logic [7:0] wake_fall_q;
	logic [7:0] pend_q;
	logic [7:0] pend_d;
	logic [7:0] cmp_q;
	logic [7:0] pin_s1_q [3];
	logic [7:0] pin_s2_q [3];
	logic [7:0] pb_prev_q;
	logic cmp_s1_q;
	logic cmp_s2_q;
	logic [7:0] port_mask [3];
	logic [2:0] port_live;
	logic [7:0] wake_edge;
	logic [7:0] cmp_view;
	logic xchg_pend;
	logic xchg_cmp;
	logic [7:0] pin_out_q [3];
	logic [7:0] pin_oe_n_q [3];

	// Port A has four pins; port C may be bonded out entirely
	assign port_mask[0] = MASK_PORT_A;
	assign port_mask[1] = MASK_FULL;
	assign port_mask[2] = MASK_FULL;
	assign port_live = {HAS_PORT_C, 1'b1, 1'b1};

	// Selector, reachable only from its own strobes
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			sel_q <= SEL_RESET;
		end else if (SEL_WR) begin
			sel_q <= SEL_WDATA; // Held until next strobe
		end
	end
	assign SEL_RDATA = sel_q;

	// Two-stage synchronisers on every pin and the comparator
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			for (int p = 0; p < 3; p++) begin
				pin_s1_q[p] <= DATA_RESET;
				pin_s2_q[p] <= DATA_RESET;
			end
			pb_prev_q <= DATA_RESET;
			cmp_s1_q <= 1'b0;
			cmp_s2_q <= 1'b0;
		end else begin
			pin_s1_q[0] <= PA_IN;
			pin_s1_q[1] <= PB_IN;
			pin_s1_q[2] <= PC_IN;
			for (int p = 0; p < 3; p++) begin
				pin_s2_q[p] <= pin_s1_q[p];
			end
			pb_prev_q <= pin_s2_q[1];
			cmp_s1_q <= CMP_GT;
			cmp_s2_q <= cmp_s1_q;
		end
	end

	// Configuration registers; unmatched port and code pairs fall through
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			for (int p = 0; p < 3; p++) begin
				cfg_q[p] <= {CFG_RESET, CFG_RESET, CFG_RESET, CFG_RESET};
			end
		end else if (PCTL_WR && PCTL_PORT < 2'h3 && port_live[PCTL_PORT]) begin
			case (sel_q)
				SEL_DIRECTION: cfg_q[PCTL_PORT].dir_in <= PCTL_WDATA | ~port_mask[PCTL_PORT];
				SEL_PULLUP: cfg_q[PCTL_PORT].pad.pullup_off <= PCTL_WDATA | ~port_mask[PCTL_PORT];
				SEL_LEVEL: cfg_q[PCTL_PORT].pad.ttl_level <= PCTL_WDATA | ~port_mask[PCTL_PORT];
				SEL_SCHMITT: begin
					// Port A pads have no Schmitt stage
					if (PCTL_PORT != PORT_A) begin
						cfg_q[PCTL_PORT].pad.schmitt_off <= PCTL_WDATA;
					end
				end
				default: ;
			endcase
		end
	end

	// Port B wake and comparator control words
	assign xchg_pend = PCTL_WR && PCTL_PORT == PORT_B && sel_q == SEL_WAKE_PEND;
	assign xchg_cmp = PCTL_WR && PCTL_PORT == PORT_B && sel_q == SEL_COMPARATOR;
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			wake_en_n_q <= CFG_RESET;
			wake_fall_q <= CFG_RESET;
			cmp_q <= CFG_RESET;
		end else if (PCTL_WR && PCTL_PORT == PORT_B) begin
			case (sel_q)
				SEL_WAKE_EN: wake_en_n_q <= PCTL_WDATA;
				SEL_WAKE_EDGE: wake_fall_q <= PCTL_WDATA;
				SEL_COMPARATOR: cmp_q <= PCTL_WDATA;
				default: ;
			endcase
		end
	end

	// Edge seen on synchronised pins; zero enable bit arms the pin
	assign wake_edge = ~wake_en_n_q & ((~wake_fall_q & pin_s2_q[1] & ~pb_prev_q) |
		(wake_fall_q & ~pin_s2_q[1] & pb_prev_q));

	// A new edge in the swap cycle survives: set beats the software write
	always_comb begin
		pend_d = xchg_pend ? PCTL_WDATA : pend_q;
		pend_d = pend_d | wake_edge;
	end
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			pend_q <= CFG_RESET;
		end else begin
			pend_q <= pend_d;
		end
	end

	// Result bit is live from the sensed comparator, zero while disabled
	assign cmp_view = {cmp_q[CMP_EN_N_BIT:CMP_RESULT_BIT + 1], cmp_s2_q & ~cmp_q[CMP_EN_N_BIT]};

	// Old contents handed back to the working register after a swap
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			PCTL_XVALID <= 1'b0;
			PCTL_XDATA <= DATA_RESET;
		end else begin
			PCTL_XVALID <= xchg_pend || xchg_cmp;
			if (xchg_pend) begin
				PCTL_XDATA <= pend_q;
			end else if (xchg_cmp) begin
				PCTL_XDATA <= cmp_view;
			end
		end
	end

	// Data latches take writes whatever the direction
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			for (int p = 0; p < 3; p++) begin
				data_q[p] <= DATA_RESET;
			end
			ram_q <= DATA_RESET;
		end else if (MEM_WR) begin
			if (MEM_ADDR == ADDR_PORT_A) begin
				data_q[0] <= MEM_WDATA & MASK_PORT_A;
			end
			if (MEM_ADDR == ADDR_PORT_B) begin
				data_q[1] <= MEM_WDATA;
			end
			if (MEM_ADDR == ADDR_PORT_C) begin
				if (HAS_PORT_C) begin
					data_q[2] <= MEM_WDATA;
				end else begin
					ram_q <= MEM_WDATA;
				end
			end
		end
	end

	// Reads return pin levels; unmapped addresses answer zero with no hit
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			MEM_HIT <= 1'b0;
			MEM_RDATA <= DATA_RESET;
		end else begin
			MEM_HIT <= (MEM_RD || MEM_WR) && MEM_ADDR >= ADDR_PORT_A && MEM_ADDR <= ADDR_PORT_C;
			if (!MEM_RD) begin
				MEM_RDATA <= DATA_RESET;
			end else if (MEM_ADDR == ADDR_PORT_A) begin
				MEM_RDATA <= pin_s2_q[0] & MASK_PORT_A;
			end else if (MEM_ADDR == ADDR_PORT_B) begin
				MEM_RDATA <= pin_s2_q[1];
			end else if (MEM_ADDR == ADDR_PORT_C) begin
				MEM_RDATA <= HAS_PORT_C ? pin_s2_q[2] : ram_q;
			end else begin
				MEM_RDATA <= DATA_RESET;
			end
		end
	end

	// Pin drivers; comparator may take over pin B0 as an output
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			for (int p = 0; p < 3; p++) begin
				pin_out_q[p] <= DATA_RESET;
				pin_oe_n_q[p] <= CFG_RESET;
			end
		end else begin
			for (int p = 0; p < 3; p++) begin
				pin_out_q[p] <= data_q[p] & port_mask[p];
				pin_oe_n_q[p] <= port_live[p] ? (cfg_q[p].dir_in | ~port_mask[p]) : CFG_RESET;
			end
			if (!cmp_q[CMP_EN_N_BIT] && !cmp_q[CMP_OUT_N_BIT]) begin
				pin_out_q[1][CMP_PIN_BIT] <= cmp_s2_q;
				pin_oe_n_q[1][CMP_PIN_BIT] <= 1'b0;
			end
		end
	end
	assign PA_OUT = pin_out_q[0];
	assign PA_OE_N = pin_oe_n_q[0];
	assign PB_OUT = pin_out_q[1];
	assign PB_OE_N = pin_oe_n_q[1];
	assign PC_OUT = pin_out_q[2];
	assign PC_OE_N = pin_oe_n_q[2];
	assign PA_PAD = cfg_q[0].pad;
	assign PB_PAD = cfg_q[1].pad;
	assign PC_PAD = cfg_q[2].pad;
	assign CMP_ENABLE_N = cmp_q[CMP_EN_N_BIT];
	assign WAKE_PENDING = pend_q;

	// Checks on the bank
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (SYS_RST);

	sequence s_dir_write;
		PCTL_WR && sel_q == SEL_DIRECTION && PCTL_PORT == PORT_B;
	endsequence
	sequence s_pend_swap;
		PCTL_WR && sel_q == SEL_WAKE_PEND && PCTL_PORT == PORT_B;
	endsequence

	a_sel_holds: assert property (!SEL_WR |=> sel_q == $past(sel_q))
		else $error("selector changed without a write");
	a_sel_reset: assert property (@(posedge REF_CLK) $fell(SYS_RST) |-> sel_q == SEL_RESET)
		else $error("selector not at direction code after reset");
	a_dir_to_oe: assert property (s_dir_write ##1 (!PCTL_WR && !SEL_WR)
		|=> PB_OE_N[7:1] == $past(PCTL_WDATA[7:1], 2))
		else $error("direction write did not reach pin enables");
	a_pend_swap: assert property (s_pend_swap |=> PCTL_XVALID && PCTL_XDATA == $past(pend_q))
		else $error("pending swap returned wrong value");
	a_pend_set: assert property ((wake_edge != DATA_RESET) |=> (pend_q & $past(wake_edge)) == $past(wake_edge))
		else $error("wake edge did not set pending flag");
	a_porta_st: assert property (cfg_q[0].pad.schmitt_off == CFG_RESET)
		else $error("port A Schmitt bits changed");
	a_porta_high: assert property (PA_OE_N[7:4] == 4'hf && PA_OUT[7:4] == 4'h0)
		else $error("port A upper pins active");
	a_read_pins: assert property (MEM_RD && MEM_ADDR == ADDR_PORT_B |=> MEM_RDATA == $past(pin_s2_q[1]))
		else $error("port B read did not return pin levels");
	a_cmp_swap: assert property (xchg_cmp |=> PCTL_XDATA == $past(cmp_view)
		&& cmp_q[7:1] == $past(PCTL_WDATA[7:1]))
		else $error("comparator swap mismatch");
	a_no_xchg_a: assert property (PCTL_WR && PCTL_PORT == PORT_A |=> !PCTL_XVALID)
		else $error("swap answered for port A");
endmodule : pcs_port_bank

// [pkg/pcs_pkg.sv]
/*
 * Constants, field layouts and carrier types for the port configuration bank.
 * Assumes one core clock; the core side of every port is on that clock.
 */
// How it works
// - Selector is loaded and read only through its own core port, never data memory.
// - Port-control write goes to the register picked by selector codes 0fh down to 08h.
// - Reset loads the selector with 0fh, the direction code.
// - A selector value holds for all later port-control writes until rewritten.
// - Selector 0fh writes direction: one is high-impedance input, zero drives.
// - Selector 0eh writes pull-up bits: one disconnects, zero connects.
// - Selector 0dh writes threshold bits: one TTL, zero CMOS, when Schmitt off.
// - Selector 0ch writes Schmitt bits of ports B and C: zero enables Schmitt.
// - Selector 0bh writes wake enable of port B: zero enables detection.
// - Selector 0ah writes wake edge of port B: zero rising, one falling.
// - Selector 09h on port B swaps working data with the wake pending flags.
// - A valid edge on an enabled wake pin sets its pending flag.
// - Selector 08h on port B swaps working data with the comparator register.
// - Comparator bit 7 clear enables it; bit 6 clear drives result onto pin B0.
// - Comparator bit 0 reads one when pin B2 voltage exceeds pin B1.
// - Reset loads every configuration register with ffh.
// - Port data registers sit at data addresses 05h, 06h and 07h.
// - Without port C, address 07h is a plain RAM byte.
// - Reading a port data register returns pin levels, not the latch.
// - Writes to input pins are latched and appear once the pin drives.
// - Port A uses only its low four bits in data and configuration.
package pcs_pkg;
	localparam logic [7:0] SEL_COMPARATOR = 8'h08;
	localparam logic [7:0] SEL_WAKE_PEND = 8'h09;
	localparam logic [7:0] SEL_WAKE_EDGE = 8'h0a;
	localparam logic [7:0] SEL_WAKE_EN = 8'h0b;
	localparam logic [7:0] SEL_SCHMITT = 8'h0c;
	localparam logic [7:0] SEL_LEVEL = 8'h0d;
	localparam logic [7:0] SEL_PULLUP = 8'h0e;
	localparam logic [7:0] SEL_DIRECTION = 8'h0f;
	localparam logic [7:0] SEL_RESET = SEL_DIRECTION;
	localparam logic [7:0] CFG_RESET = 8'hff;
	localparam logic [7:0] ADDR_PORT_A = 8'h05;
	localparam logic [7:0] ADDR_PORT_B = 8'h06;
	localparam logic [7:0] ADDR_PORT_C = 8'h07;
	localparam logic [7:0] MASK_PORT_A = 8'h0f;
	localparam logic [7:0] MASK_FULL = 8'hff;
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam logic [1:0] PORT_A = 2'h0;
	localparam logic [1:0] PORT_B = 2'h1;
	localparam logic [1:0] PORT_C = 2'h2;
	localparam int CMP_EN_N_BIT = 7;
	localparam int CMP_OUT_N_BIT = 6;
	localparam int CMP_RESULT_BIT = 0;
	localparam int CMP_PIN_BIT = 0;
	// Pad controls that travel to the analog pad ring together
	typedef struct packed {
		logic [7:0] pullup_off;
		logic [7:0] ttl_level;
		logic [7:0] schmitt_off;
	} pcs_pad_cfg_t;
	// One port's configuration as held in the bank
	typedef struct packed {
		logic [7:0] dir_in;
		pcs_pad_cfg_t pad;
	} pcs_port_cfg_t;
endpackage : pcs_pkg

// [testbench/pcs_core_model.sv]
/*
 * Core model: issues selector loads, port-control moves and data accesses.
 * Assumes the bank takes each strobe on the rising edge of clk.
 */
module pcs_core_model (
	input wire logic clk,
	output logic sel_wr,
	output logic [7:0] sel_wdata,
	output logic pctl_wr,
	output logic [1:0] pctl_port,
	output logic [7:0] pctl_wdata,
	input wire logic pctl_xvalid,
	input wire logic [7:0] pctl_xdata,
	output logic [7:0] mem_addr,
	output logic mem_wr,
	output logic mem_rd,
	output logic [7:0] mem_wdata,
	input wire logic mem_hit,
	input wire logic [7:0] mem_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	// Idle bus at time zero
	initial begin
		{sel_wr, pctl_wr, mem_wr, mem_rd} = 4'h0;
		{sel_wdata, pctl_wdata, mem_wdata, mem_addr} = 32'h0;
		pctl_port = 2'h0;
	end
	// Only codes 08h to 0fh ever reach the selector
	task automatic set_sel(input logic [7:0] v);
		@(negedge clk);
		sel_wr = 1'b1;
		sel_wdata = {5'h01, v[2:0]};
		@(negedge clk);
		sel_wr = 1'b0;
		sel_wdata = ~sel_wdata;
	endtask : set_sel
	// Released data is inverted so stale values never look valid
	task automatic pctl(input logic [1:0] p, input logic [7:0] v, output logic xv, output logic [7:0] xd);
		@(negedge clk);
		pctl_wr = 1'b1;
		pctl_port = p;
		pctl_wdata = v;
		@(negedge clk);
		xv = pctl_xvalid;
		xd = pctl_xdata;
		pctl_wr = 1'b0;
		pctl_wdata = ~pctl_wdata;
	endtask : pctl
	// One data memory read or write
	task automatic mem(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic h,
		output logic [7:0] r);
		@(negedge clk);
		mem_wr = wr;
		mem_rd = ~wr;
		mem_addr = a;
		mem_wdata = d;
		@(negedge clk);
		h = mem_hit;
		r = mem_rdata;
		{mem_wr, mem_rd} = 2'h0;
		mem_wdata = ~mem_wdata;
	endtask : mem
endmodule : pcs_core_model

// [testbench/tb.sv]
/*
 * Bench for the port configuration bank: core model, pin resolution and
 * an integer model of the bank compared at every result.
 * Assumes pcs_core_model drives the core side.
 */
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import pcs_pkg::*;
	logic clk, rst, cmp_gt, xv, hit, sel_wr, pctl_wr, mem_wr, mem_rd, cmp_en_n, pctl_xv, mem_hit;
	logic [1:0] port;
	logic [7:0] v, xd, rd, sel_wd, sel_rd, pctl_wd, pctl_xd, addr, mem_wd, mem_rd8, wake;
	logic [2:0][7:0] ext, oe, po, pi;
	pcs_pad_cfg_t [2:0] pad;
	logic [7:0] nc_rd, nc_oe;
	int n_fail, num_checks, lat, ram;
	int cfg [3][16];
	int q [$];
	// Pin level: driven value where enabled, else the outside world
	assign pi = (~oe & po) | (oe & ext);
	pcs_port_bank dut (
		.REF_CLK(clk), .SYS_RST(rst), .SEL_WR(sel_wr), .SEL_WDATA(sel_wd), .SEL_RDATA(sel_rd),
		.PCTL_WR(pctl_wr), .PCTL_PORT(port), .PCTL_WDATA(pctl_wd), .PCTL_XVALID(pctl_xv),
		.PCTL_XDATA(pctl_xd), .MEM_ADDR(addr), .MEM_WR(mem_wr), .MEM_RD(mem_rd), .MEM_WDATA(mem_wd),
		.MEM_HIT(mem_hit), .MEM_RDATA(mem_rd8), .PA_IN(pi[0]), .PA_OUT(po[0]), .PA_OE_N(oe[0]),
		.PB_IN(pi[1]), .PB_OUT(po[1]), .PB_OE_N(oe[1]), .PC_IN(pi[2]), .PC_OUT(po[2]),
		.PC_OE_N(oe[2]), .PA_PAD(pad[0]), .PB_PAD(pad[1]), .PC_PAD(pad[2]), .CMP_GT(cmp_gt),
		.CMP_ENABLE_N(cmp_en_n), .WAKE_PENDING(wake)
	);
	pcs_core_model core (
		.clk(clk), .sel_wr(sel_wr), .sel_wdata(sel_wd), .pctl_wr(pctl_wr), .pctl_port(port),
		.pctl_wdata(pctl_wd), .pctl_xvalid(pctl_xv), .pctl_xdata(pctl_xd), .mem_addr(addr),
		.mem_wr(mem_wr), .mem_rd(mem_rd), .mem_wdata(mem_wd), .mem_hit(mem_hit), .mem_rdata(mem_rd8)
	);
	// Same bank without port C; its 07h must behave as a plain RAM byte
	pcs_port_bank #(.HAS_PORT_C(1'b0)) dut_nc (
		.REF_CLK(clk), .SYS_RST(rst), .SEL_WR(sel_wr), .SEL_WDATA(sel_wd), .SEL_RDATA(),
		.PCTL_WR(pctl_wr), .PCTL_PORT(port), .PCTL_WDATA(pctl_wd), .PCTL_XVALID(), .PCTL_XDATA(),
		.MEM_ADDR(addr), .MEM_WR(mem_wr), .MEM_RD(mem_rd), .MEM_WDATA(mem_wd), .MEM_HIT(),
		.MEM_RDATA(nc_rd), .PA_IN(pi[0]), .PA_OUT(), .PA_OE_N(), .PB_IN(pi[1]), .PB_OUT(), .PB_OE_N(),
		.PC_IN(pi[2]), .PC_OUT(), .PC_OE_N(nc_oe), .PA_PAD(), .PB_PAD(), .PC_PAD(), .CMP_GT(cmp_gt),
		.CMP_ENABLE_N(), .WAKE_PENDING()
	);
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic conclude();
		if (n_fail == 0 && num_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : conclude
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	// Hang guard
	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		conclude();
	end
	initial begin
		rst = 1'b1;
		cmp_gt = 1'b0;
		ext = 24'h5a_c0_0a;
		n_fail = 0;
		num_checks = 0;
		foreach (cfg[p, c]) cfg[p][c] = 255;
		void'($urandom(32'h8653));
		repeat (20) @(negedge clk);
		rst = 1'b0;
		chk(sel_rd, SEL_RESET);
		for (int p = 0; p < 3; p++) chk(pad[p][23:16] & pad[p][15:8] & pad[p][7:0] & oe[p], CFG_RESET);
		chk(wake & {cmp_en_n, 7'h7f}, CFG_RESET);
		// Every code on every port; wake and comparator codes on port B come later
		for (int c = 8; c < 16; c++) begin
			core.set_sel(8'(c));
			chk(sel_rd, 8'(c));
			for (int p = 0; p < 4; p++) begin
				if (p == 1 && c < 12) continue;
				v = 8'($urandom);
				core.pctl(2'(p), v, xv, xd);
				if (p < 3 && c > 11 && !(p == 0 && c == 12)) cfg[p][c] = (p == 0) ? int'(v | 8'hf0) : int'(v);
				chk({7'h0, xv}, 8'h00);
				for (int k = 0; k < 3 && p < 3; k++) chk(pad[p][8*k +: 8], 8'(cfg[p][12+k]));
			end
			if (c == 15) begin
				@(negedge clk);
				for (int p = 0; p < 3; p++) chk(oe[p], 8'(cfg[p][15]));
			end
		end
		chk(nc_oe, CFG_RESET);
		// Latches written while some pins are inputs
		for (int p = 0; p < 3; p++) begin
			v = 8'($urandom);
			core.mem(1'b1, ADDR_PORT_A + 8'(p), v, hit, rd);
			lat = (p == 0) ? int'(v & MASK_PORT_A) : int'(v);
			if (p == 2) ram = lat;
			q.push_back(((~cfg[p][15] & lat) | (cfg[p][15] & int'(ext[p]))) & (p == 0 ? 15 : 255));
		end
		repeat (4) @(negedge clk);
		for (int p = 0; p < 3; p++) begin
			core.mem(1'b0, ADDR_PORT_A + 8'(p), 8'h00, hit, rd);
			chk(rd, 8'(q.pop_front()));
			if (p == 2) chk(nc_rd, 8'(ram));
			chk({7'h0, hit}, 8'h01);
		end
		core.mem(1'b0, 8'h04, 8'h00, hit, rd);
		chk(rd | {7'h0, hit}, 8'h00);
		// Wake on pin 0 only, rising first
		core.set_sel(SEL_DIRECTION);
		core.pctl(2'h1, 8'hff, xv, xd);
		repeat (4) @(negedge clk);
		core.set_sel(SEL_WAKE_EN);
		core.pctl(2'h1, 8'hfe, xv, xd);
		core.set_sel(SEL_WAKE_EDGE);
		core.pctl(2'h1, 8'h00, xv, xd);
		core.set_sel(SEL_WAKE_PEND);
		core.pctl(2'h1, 8'h00, xv, xd);
		chk(xd & {8{xv}}, CFG_RESET);
		chk(wake, 8'h00);
		ext[1][1:0] = 2'b11;
		repeat (4) @(negedge clk);
		chk(wake, 8'h01);
		core.set_sel(SEL_WAKE_EDGE);
		core.pctl(2'h1, 8'h01, xv, xd);
		core.set_sel(SEL_WAKE_PEND);
		core.pctl(2'h1, 8'h00, xv, xd);
		chk(xd & {8{xv}}, 8'h01);
		ext[1][0] = 1'b0;
		repeat (4) @(negedge clk);
		chk(wake, 8'h01);
		// Comparator on, result driven onto pin 0
		core.set_sel(SEL_COMPARATOR);
		core.pctl(2'h1, 8'h3e, xv, xd);
		chk(xd & {8{xv}}, {CFG_RESET[7:1], 1'b0});
		cmp_gt = 1'b1;
		repeat (4) @(negedge clk);
		chk({6'h0, cmp_en_n, oe[1][0]}, 8'h00);
		chk({7'h0, po[1][0]}, 8'h01);
		core.pctl(2'h1, 8'hff, xv, xd);
		chk(xd & {8{xv}}, 8'h3f);
		conclude();
	end
endmodule : tb
